// ===== common/timed_io_pkg.sv
// timed_io_pkg: sizes, register offsets, field positions and reset
// values for the timed i/o ports and their clock blocks.
// assumes a 7-bit word address on a plain register port.
package timed_io_pkg;

    // structure
    localparam int NP   = 5;   // ports
    localparam int NCB  = 6;   // clock blocks per tile
    localparam int NPIN = 32;  // pins shared by the ports

    // pin coverage of each port, narrowest first: 1, 4, 8, 16, 32 bits
    localparam logic [31:0] PORT_MASK [NP] = '{
        32'h0000_0001, 32'h0000_000f, 32'h0000_00ff,
        32'h0000_ffff, 32'hffff_ffff};

    // pins taken over when the inter-switch link is enabled
    localparam logic [31:0] LINK_MASK = 32'hffff_0000;

    // address layout: bit 6 selects clock blocks, then unit, then reg
    localparam int          ADDR_W  = 7;
    localparam int          CB_SEL  = 6;
    localparam logic [2:0]  OFS_CTRL  = 3'h0;
    localparam logic [2:0]  OFS_DATA  = 3'h1;
    localparam logic [2:0]  OFS_TIME  = 3'h2;
    localparam logic [2:0]  OFS_COND  = 3'h3;
    localparam logic [2:0]  OFS_COUNT = 3'h4;
    localparam logic [2:0]  OFS_STAMP = 3'h5;
    localparam logic [2:0]  OFS_STAT  = 3'h6;

    // port control fields
    localparam int CTL_EN    = 0;  // port enabled
    localparam int CTL_OUT   = 1;  // direction: 1 output
    localparam int CTL_OD    = 2;  // open-drain drive
    localparam int CTL_TIMED = 3;  // wait for count == time
    localparam int CTL_SIN   = 4;  // qualify input with strobe
    localparam int CTL_SOUT  = 5;  // emit strobe with output
    localparam int CTL_CND   = 6;  // 2-bit pin condition
    localparam int CTL_CB    = 8;  // 3-bit clock block select
    localparam logic [15:0] CTRL_RST = 16'h0000;  // clock block 0

    // status fields
    localparam int STA_VALID = 0;
    localparam int STA_PEND  = 1;

    // clock block control fields
    localparam int CB_SRC = 0;     // 1: external 1-bit port pin
    localparam int CB_DIV = 8;     // 8-bit divide, n means /(n+1)
    localparam logic [15:0] CB_RST = 16'h0000;

    localparam logic [15:0] CNT_RST = 16'h0000;

    // pin condition for sampling
    typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NE} cond_t;

endpackage

// ===== core/timed_io_ports.sv
// timed_io_ports: five timed i/o ports sharing 32 pins, and six clock
// blocks that pace them, behind a plain register port.
// assumes inputs synchronous to clock_in; pin wire resolved outside.
//
// Overview of operation
// R1 - ports of 1, 4, 8, 16, 32 bits
// R2 - one direction for all pins of a port
// R3 - drive or sample pins, optionally on condition
// R4 - every port access completes in one cycle
// R5 - open drain: drive zero low, float one
// R6 - open-drain choice held per port
// R7 - shift stage plus transfer register per port
// R8 - 16-bit port counter gates transfers
// R9 - counter readable; timed transfer at count
// R10 - counter captured as timestamp on transfer
// R11 - pin condition raises event to tile
// R12 - enabled link disables ports on its pins
// R13 - narrower enabled port wins shared pins
// R14 - unshared pins stay with wider port
// R15 - ports move words of nominal width
// R16 - six clock blocks; block 0 is reference
// R17 - clock block may use 1-bit port clock
// R18 - external clock optionally divided
// R19 - ready strobes taken in and given out
// R20 - after reset every port uses block 0
// R21 - counter steps per clock block tick, wraps
// R22 - sampling and strobes on block tick
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps

module timed_io_ports
    import timed_io_pkg::*;
(
    // clock and reset
    input  wire logic                clock_in,
    input  wire logic                rst_b_in,
    // register port
    input  wire logic [ADDR_W-1:0]   reg_addr_in,
    input  wire logic [31:0]         reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    output logic      [31:0]         reg_rdata_out,
    // pins
    input  wire logic [NPIN-1:0]     pin_in,
    output logic      [NPIN-1:0]     pin_out,
    output logic      [NPIN-1:0]     pin_oe_out,
    input  wire logic                link_en_in,
    input  wire logic                clk_pin_in,
    // strobes and events
    input  wire logic [NP-1:0]       strobe_from_external_in,
    output logic      [NP-1:0]       strobe_to_external_out,
    output logic      [NP-1:0]       event_out
);

    // per-port views for the pin mux and the read mux
    logic [31:0] drv_a   [NP];
    logic [15:0] ctrl_a  [NP];
    logic [31:0] xfer_a  [NP];
    logic [15:0] time_a  [NP];
    logic [31:0] cond_a  [NP];
    logic [15:0] cnt_a   [NP];
    logic [15:0] stamp_a [NP];
    logic [1:0]  stat_a  [NP];
    logic [15:0] cbc_a   [NCB];
    logic [NCB-1:0] cb_tick;
    logic        ev_a    [NP];
    logic        so_a    [NP];

    logic        sync1_q;
    logic        sync2_q;
    logic        sync3_q;
    logic        ext_rise;
    logic [31:0] rd_d;
    logic [31:0] rdata_q;
    logic [NPIN-1:0] pout_q;
    logic [NPIN-1:0] poe_q;
    logic [NP-1:0]   sto_q;
    logic [NP-1:0]   ev_q;

    logic        is_cb;
    logic [2:0]  unit;
    logic [2:0]  ofs;

    assign is_cb = reg_addr_in[CB_SEL];
    assign unit  = reg_addr_in[5:3];
    assign ofs   = reg_addr_in[2:0];

    // external clock pin synchroniser; edge taken after second stage
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= clk_pin_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign ext_rise = sync2_q & ~sync3_q; // R17

    // clock blocks: each gives a one-cycle tick at its active edge
    genvar c;
    generate
        for (c = 0; c < NCB; c++) begin : g_cb
            logic [15:0] cbc_q;
            logic [7:0]  dcnt_q;
            logic        tick_q;
            logic        src;
            logic        cb_wr;

            assign cb_wr = reg_wr_in && is_cb && (unit == 3'(c))
                           && (ofs == OFS_CTRL);
            // block 0 always runs from the reference clock
            assign src = (c == 0) ? 1'b1 : // R16
                         (cbc_q[CB_SRC] ? ext_rise : 1'b1); // R17

            // control: block 0 is fixed, others programmable
            always_ff @(posedge clock_in) begin
                if (!rst_b_in) begin
                    cbc_q <= CB_RST;
                end else if (cb_wr && c != 0) begin
                    cbc_q <= reg_wdata_in[15:0]; // R16
                end
            end

            // divider of the selected source
            always_ff @(posedge clock_in) begin
                if (!rst_b_in) begin
                    dcnt_q <= 8'h00;
                    tick_q <= 1'b0;
                end else begin
                    tick_q <= 1'b0;
                    if (src) begin
                        if (dcnt_q >= cbc_q[CB_DIV +: 8]) begin
                            dcnt_q <= 8'h00;
                            tick_q <= 1'b1; // R18
                        end else begin
                            dcnt_q <= dcnt_q + 8'h01;
                        end
                    end
                end
            end

            assign cb_tick[c] = tick_q;
            assign cbc_a[c]   = cbc_q;
        end
    endgenerate

    // ports
    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            logic [15:0] ctrl_q;
            logic [31:0] xfer_q;
            logic [31:0] shift_q;
            logic [31:0] cond_q;
            logic [15:0] time_q;
            logic [15:0] cnt_q;
            logic [15:0] stamp_q;
            logic        pend_q;
            logic        valid_q;
            logic        move_q;
            logic        ev_pq;
            logic        so_pq;
            logic [2:0]  sel;
            logic        tick;
            logic [31:0] samp;
            logic        cond_ok;
            logic        time_ok;
            logic        strb_ok;
            logic        go_out;
            logic        go_in;
            logic        hit;
            cond_t       mode;

            assign hit  = !is_cb && (unit == 3'(p));
            assign sel  = ctrl_q[CTL_CB +: 3];
            assign tick = (sel < 3'(NCB)) ? cb_tick[sel] : 1'b0; // R22
            assign samp = pin_in & PORT_MASK[p]; // R1 R15
            assign mode = cond_t'(ctrl_q[CTL_CND +: 2]);

            // pin condition on the sampled word
            always_comb begin
                case (mode)
                    COND_NONE: cond_ok = 1'b1;
                    COND_EQ:   cond_ok = (samp == cond_q); // R3
                    COND_NE:   cond_ok = (samp != cond_q); // R3
                    default:   cond_ok = 1'b1;
                endcase
            end

            assign time_ok = !ctrl_q[CTL_TIMED] || (cnt_q == time_q); // R9
            assign strb_ok = !ctrl_q[CTL_SIN]
                             || strobe_from_external_in[p]; // R19
            assign go_out = ctrl_q[CTL_EN] && ctrl_q[CTL_OUT] && tick
                            && pend_q && time_ok; // R8
            assign go_in  = ctrl_q[CTL_EN] && !ctrl_q[CTL_OUT] && tick
                            && time_ok && cond_ok && strb_ok; // R8

            // control, time and condition registers
            always_ff @(posedge clock_in) begin
                if (!rst_b_in) begin
                    ctrl_q <= CTRL_RST; // R20
                    time_q <= CNT_RST;
                    cond_q <= 32'h0000_0000;
                end else if (reg_wr_in && hit) begin // R4
                    if (ofs == OFS_CTRL) begin
                        ctrl_q <= reg_wdata_in[15:0]; // R2 R6
                    end
                    if (ofs == OFS_TIME) begin
                        time_q <= reg_wdata_in[15:0];
                    end
                    if (ofs == OFS_COND) begin
                        cond_q <= reg_wdata_in & PORT_MASK[p];
                    end
                end
            end

            // port counter, wraps through zero
            always_ff @(posedge clock_in) begin
                if (!rst_b_in) begin
                    cnt_q <= CNT_RST;
                end else if (tick) begin
                    cnt_q <= cnt_q + 16'h0001; // R21
                end
            end

            // shift stage and transfer register
            always_ff @(posedge clock_in) begin
                if (!rst_b_in) begin
                    xfer_q  <= 32'h0000_0000;
                    shift_q <= 32'h0000_0000;
                    pend_q  <= 1'b0;
                    move_q  <= 1'b0;
                    valid_q <= 1'b0;
                end else begin
                    move_q <= go_in;
                    if (go_in) begin
                        shift_q <= samp; // R7
                    end else if (go_out) begin
                        shift_q <= xfer_q; // R7
                    end
                    if (move_q) begin
                        xfer_q <= shift_q; // R7
                    end else if (reg_wr_in && hit && ofs == OFS_DATA) begin
                        xfer_q <= reg_wdata_in & PORT_MASK[p]; // R15
                    end
                    // a new write wins over the transfer that empties
                    if (reg_wr_in && hit && ofs == OFS_DATA) begin
                        pend_q <= 1'b1;
                    end else if (go_out) begin
                        pend_q <= 1'b0;
                    end
                    // new data wins over a read that clears valid
                    if (move_q) begin
                        valid_q <= 1'b1;
                    end else if (reg_rd_in && hit && ofs == OFS_DATA) begin
                        valid_q <= 1'b0;
                    end
                end
            end

            // timestamp, event and outgoing strobe
            always_ff @(posedge clock_in) begin
                if (!rst_b_in) begin
                    stamp_q <= CNT_RST;
                    ev_pq   <= 1'b0;
                    so_pq   <= 1'b0;
                end else begin
                    if (go_in || go_out) begin
                        stamp_q <= cnt_q; // R10
                    end
                    ev_pq <= go_in && (mode != COND_NONE); // R11
                    so_pq <= go_out && ctrl_q[CTL_SOUT]; // R19 R22
                end
            end

            // drive request: one direction per port
            assign drv_a[p]   = shift_q;
            assign ctrl_a[p]  = ctrl_q;
            assign xfer_a[p]  = xfer_q;
            assign time_a[p]  = time_q;
            assign cond_a[p]  = cond_q;
            assign cnt_a[p]   = cnt_q;
            assign stamp_a[p] = stamp_q;
            assign stat_a[p]  = {pend_q, valid_q};
            assign ev_a[p]    = ev_pq;
            assign so_a[p]    = so_pq;
        end
    endgenerate

    // pin sharing: widest first, so narrower enabled ports overwrite
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            pout_q <= 32'h0000_0000;
            poe_q  <= 32'h0000_0000;
        end else begin
            for (int b = 0; b < NPIN; b++) begin
                pout_q[b] <= 1'b0;
                poe_q[b]  <= 1'b0;
                for (int k = NP - 1; k >= 0; k--) begin
                    if (ctrl_a[k][CTL_EN] && PORT_MASK[k][b]) begin // R13 R14
                        if (!ctrl_a[k][CTL_OUT]) begin
                            poe_q[b] <= 1'b0; // R2
                            pout_q[b] <= 1'b0;
                        end else if (ctrl_a[k][CTL_OD]) begin
                            pout_q[b] <= 1'b0; // R5
                            poe_q[b]  <= ~drv_a[k][b]; // R5 R6
                        end else begin
                            pout_q[b] <= drv_a[k][b]; // R3
                            poe_q[b]  <= 1'b1;
                        end
                    end
                end
                // an enabled link takes its pins from every port
                if (link_en_in && LINK_MASK[b]) begin
                    pout_q[b] <= 1'b0; // R12
                    poe_q[b]  <= 1'b0; // R12
                end
            end
        end
    end

    // strobe and event outputs
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            sto_q <= '0;
            ev_q  <= '0;
        end else begin
            for (int k = 0; k < NP; k++) begin
                sto_q[k] <= so_a[k];
                ev_q[k]  <= ev_a[k]; // R11
            end
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        rd_d = 32'h0000_0000;
        if (is_cb) begin
            if (unit < 3'(NCB) && ofs == OFS_CTRL) begin
                rd_d = {16'h0000, cbc_a[unit]};
            end
        end else if (unit < 3'(NP)) begin
            case (ofs)
                OFS_CTRL:  rd_d = {16'h0000, ctrl_a[unit]};
                OFS_DATA:  rd_d = xfer_a[unit];
                OFS_TIME:  rd_d = {16'h0000, time_a[unit]};
                OFS_COND:  rd_d = cond_a[unit];
                OFS_COUNT: rd_d = {16'h0000, cnt_a[unit]}; // R9
                OFS_STAMP: rd_d = {16'h0000, stamp_a[unit]}; // R10
                OFS_STAT:  rd_d = {30'h0000_0000, stat_a[unit]};
                default:   rd_d = 32'h0000_0000;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= reg_rd_in ? rd_d : 32'h0000_0000; // R4
        end
    end

    assign reg_rdata_out          = rdata_q;
    assign pin_out                = pout_q;
    assign pin_oe_out             = poe_q;
    assign strobe_to_external_out = sto_q;
    assign event_out              = ev_q;

endmodule // timed_io_ports

// ===== sim/ext_pins.sv
// ext_pins: far-side hardware on the pins, pull-downs on every pin.
// assumes the bench chooses which pins it drives and runs the clock.
`timescale 1ns/100ps
module ext_pins
    import timed_io_pkg::*;
#(
    parameter int HALF = 4  // half period of the app clock, in cycles
)(
    // clock
    input  wire logic            clock_in,
    // pins
    input  wire logic [NPIN-1:0] pin_out,
    input  wire logic [NPIN-1:0] pin_oe_out,
    input  wire logic [NPIN-1:0] drv_en_in,
    input  wire logic [NPIN-1:0] drv_val_in,
    output logic      [NPIN-1:0] pin_in,
    // application clock
    input  wire logic            clk_run_in,
    output logic                 clk_pin_out = 1'b0
);
    int cnt_q = 0;

    // wire level: device, then far side, else pulled low
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            pin_in[i] = pin_oe_out[i] ? pin_out[i] :
                        (drv_en_in[i] ? drv_val_in[i] : 1'b0);
        end
    end

    // app clock stands low unless running
    always_ff @(posedge clock_in) begin
        if (!clk_run_in) begin
            cnt_q       <= 0;
            clk_pin_out <= 1'b0;
        end else if (cnt_q == HALF - 1) begin
            cnt_q       <= 0;
            clk_pin_out <= !clk_pin_out;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule // ext_pins

// ===== sim/tb_timed_io_port_clock_blocks.sv
// tb_timed_io_port_clock_blocks: self-checking bench for the ports.
// assumes the checker is bound in and ext_pins models the far side.
`timescale 1ns/100ps
module tb_timed_io_port_clock_blocks
    import timed_io_pkg::*;
;
    logic              clock_in = 1'b0;
    logic              rst_b_in = 1'b0;
    logic [ADDR_W-1:0] reg_addr_in = 7'h00;
    logic [31:0]       reg_wdata_in = 32'h0;
    logic              reg_wr_in = 1'b0;
    logic              reg_rd_in = 1'b0;
    logic [31:0]       reg_rdata_out;
    logic [NPIN-1:0]   pin_in, pin_out, pin_oe_out;
    logic [NPIN-1:0]   drv_en = 32'h0, drv_val = 32'h0;
    logic              link_en_in = 1'b0, clk_pin_in, clk_run = 1'b0;
    logic [NP-1:0]     strobe_from_external_in = 5'h00;
    logic [NP-1:0]     strobe_to_external_out, event_out;
    logic [63:0]       exp_q [$];
    logic              rd_d = 1'b0;
    logic [31:0]       got, v0, v1, d, d2, d3;
    logic [15:0]       t;
    logic [7:0]        x;
    int                n_errors = 0, n_tests = 0, ev;

    initial forever #25 clock_in = ~clock_in;

    timed_io_ports u_dut (
        .clock_in(clock_in), .rst_b_in(rst_b_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_out(pin_oe_out),
        .link_en_in(link_en_in), .clk_pin_in(clk_pin_in),
        .strobe_from_external_in(strobe_from_external_in),
        .strobe_to_external_out(strobe_to_external_out),
        .event_out(event_out));
    ext_pins #(.HALF(4)) u_far (
        .clock_in(clock_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
        .drv_en_in(drv_en), .drv_val_in(drv_val), .pin_in(pin_in),
        .clk_run_in(clk_run), .clk_pin_out(clk_pin_in));

    task automatic finish_test();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] w);
        @(posedge clock_in);
        reg_wr_in    <= 1'b1;
        reg_rd_in    <= 1'b0;
        reg_addr_in  <= a;
        reg_wdata_in <= w;
    endtask
    task automatic rd(input logic [6:0] a, input logic [31:0] e, m);
        @(posedge clock_in);
        reg_rd_in   <= 1'b1;
        reg_wr_in   <= 1'b0;
        reg_addr_in <= a;
        exp_q.push_back({e, m});
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clock_in);
            reg_rd_in <= 1'b0;
            reg_wr_in <= 1'b0;
        end
    endtask
    task automatic get(input logic [6:0] a, output logic [31:0] v);
        rd(a, 32'h0, 32'h0);
        idle(2);
        #1 v = got;
    endtask
    task automatic wait_pins(input logic [31:0] m, v, oe);
        idle(1);
        for (int k = 0; k < 40; k++) begin
            @(negedge clock_in);
            if ((pin_oe_out & m) === (oe & m) &&
                (pin_out & m & oe) === (v & m & oe)) break;
        end
        chk(pin_oe_out & m, oe & m);
        chk(pin_out & m & oe, v & m & oe);
    endtask

    // read answers are compared against the oldest expectation
    always @(posedge clock_in) begin
        if (rd_d) begin
            got = reg_rdata_out;
            chk(got & exp_q[0][31:0], exp_q[0][63:32]);
            void'(exp_q.pop_front());
        end
        rd_d <= reg_rd_in;
    end

    initial begin
        repeat (4000) @(posedge clock_in);
        n_errors++;
        finish_test();
    end

    initial begin
        d = $urandom(32'hf1610bba);
        d = $urandom();
        d2 = $urandom();
        repeat (2) @(posedge clock_in);
        rst_b_in <= 1'b1;
        for (int u = 0; u < NP; u++) begin
            rd(7'(u * 8), 32'h0, 32'hffff);
            rd(7'(u * 8) + 7'h06, 32'h0, 32'h3);
        end
        for (int c = 0; c < NCB; c++) rd(7'h40 + 7'(c * 8), 0, 32'hffff);
        wr(7'h40, 32'h0000_0101);
        rd(7'h40, 32'h0, 32'hffff_ffff);
        rd(7'h07, 32'h0, 32'hffff_ffff);
        // port 2 drives a masked word with an outgoing strobe
        wr(7'h10, 32'h0000_0023);
        wr(7'h11, d);
        wait_pins(32'hff, d, 32'hff);
        for (int k = 0; k < 8; k++) begin
            if (strobe_to_external_out[2]) break;
            @(negedge clock_in);
        end
        chk({31'h0, strobe_to_external_out[2]}, 32'h1);
        // port 0 overrules pin 0; then open drain
        wr(7'h00, 32'h3);
        wr(7'h01, {31'h0, ~d[0]});
        wait_pins(32'hff, {d[31:1], ~d[0]}, 32'hff);
        wr(7'h00, 32'h7);
        wr(7'h01, 32'h1);
        wait_pins(32'h1, 32'h0, 32'h0);
        chk({31'h0, pin_in[0]}, 32'h0);
        wr(7'h01, 32'h0);
        wait_pins(32'h1, 32'h0, 32'h1);
        wait_pins(32'hfe, d, 32'hfe);
        // port 4 at full width, then the link takes the top pins
        wr(7'h20, 32'h3);
        wr(7'h21, d2);
        wait_pins(32'hffff_ff00, d2, 32'hffff_ff00);
        @(posedge clock_in) link_en_in <= 1'b1;
        wait_pins(32'hffff_0000, 32'h0, 32'h0);
        wait_pins(32'h0000_ff00, d2, 32'h0000_ff00);
        @(posedge clock_in) link_en_in <= 1'b0;
        // port 3 waits for its count, then stamps it
        x = (d2[15:8] == 8'h5a) ? 8'ha5 : 8'h5a;
        d3 = {16'h0, x, 8'h00};
        wr(7'h18, 32'h0000_000b);
        get(7'h1c, v0);
        t = v0[15:0] + 16'd40;
        wr(7'h1a, {16'h0, t});
        wr(7'h19, d3);
        idle(20);
        chk({31'h0, pin_out[15:8] === x}, 32'h0);
        wait_pins(32'h0000_ff00, d3, 32'h0000_ff00);
        rd(7'h1d, {16'h0, t}, 32'hffff);
        // port 0 as input: conditions and events
        drv_en[0] <= 1'b1;
        drv_val[0] <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            wr(7'h03, (c == 2) ? 32'h0 : 32'h1);
            wr(7'h00, 32'h1 | (32'(c) << 6));
            idle(3);
            ev = 0;
            repeat (12) begin
                @(negedge clock_in);
                ev += int'(event_out[0]);
            end
            chk({31'h0, ev > 0}, {31'h0, c != 0});
        end
        wait_pins(32'h1, 32'h0, 32'h0);
        rd(7'h01, 32'h1, 32'h1);
        rd(7'h04, 32'h0, 32'hffff_0000);
        get(7'h04, v0);
        get(7'h04, v1);
        chk({16'h0, v1[15:0] - v0[15:0]}, 32'h3);
        // port 1 input qualified by the incoming strobe
        wr(7'h08, 32'h0000_0011);
        idle(4);
        rd(7'h0e, 32'h0, 32'h1);
        idle(1);
        strobe_from_external_in[1] <= 1'b1;
        idle(3);
        strobe_from_external_in[1] <= 1'b0;
        rd(7'h0e, 32'h1, 32'h1);
        // clock block 1 from the pin, divided by two
        wr(7'h48, 32'h0000_0101);
        rd(7'h48, 32'h0000_0101, 32'hffff);
        wr(7'h08, 32'h0000_0101);
        idle(1);
        clk_run <= 1'b1;
        get(7'h0c, v0);
        idle(160);
        get(7'h0c, v1);
        v1 = v1 - v0;
        chk({31'h0, v1[15:0] >= 9 && v1[15:0] <= 11}, 32'h1);
        clk_run <= 1'b0;
        idle(8);
        get(7'h0c, v0);
        idle(40);
        get(7'h0c, v1);
        chk(v1, v0);
        // reset in mid-run puts everything back on block 0
        @(posedge clock_in) rst_b_in <= 1'b0;
        idle(2);
        rst_b_in <= 1'b1;
        rd(7'h08, 32'h0, 32'hffff);
        rd(7'h48, 32'h0, 32'hffff);
        idle(3);
        finish_test();
    end
endmodule // tb_timed_io_port_clock_blocks

// ===== sim/timed_io_checks_assertions.sv
// checker: port-level properties of the timed i/o ports.
// assumes binding to timed_io_ports; port 0 control is shadowed here.
`timescale 1ns/100ps
module timed_io_checks
    import timed_io_pkg::*;
(
    // watched ports
    input wire logic              clock_in,
    input wire logic              rst_b_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0]       reg_wdata_in,
    input wire logic              reg_wr_in,
    input wire logic              reg_rd_in,
    input wire logic [31:0]       reg_rdata_out,
    input wire logic [NPIN-1:0]   pin_out,
    input wire logic [NPIN-1:0]   pin_oe_out,
    input wire logic              link_en_in,
    input wire logic [NP-1:0]     strobe_to_external_out,
    input wire logic [NP-1:0]     event_out
);
    logic [15:0] ctl0_q;
    logic [1:0]  age_q;
    logic        cnt_rd_q;
    logic        settled;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    // shadow of port 0 control, aged so the pin mux has caught up
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            ctl0_q   <= CTRL_RST;
            age_q    <= 2'h0;
            cnt_rd_q <= 1'b0;
        end else begin
            cnt_rd_q <= reg_rd_in && reg_addr_in == 7'h04;
            if (reg_wr_in && reg_addr_in == 7'h00) begin
                ctl0_q <= reg_wdata_in[15:0];
                age_q  <= 2'h0;
            end else if (age_q != 2'h3) begin
                age_q <= age_q + 2'h1;
            end
        end
    end
    assign settled = age_q == 2'h3;

    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_b_in |=> pin_oe_out == 32'h0 && event_out == 5'h00 &&
        strobe_to_external_out == 5'h00 && reg_rdata_out == 32'h0)
        else $error("outputs not quiet after reset");
    a_rdata_idle: assert property (!$past(reg_rd_in) |->
        reg_rdata_out == 32'h0) else $error("read data without read");
    a_unmapped_zero: assert property (reg_rd_in &&
        reg_addr_in[2:0] == 3'h7 |=> reg_rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_block0_fixed: assert property (reg_rd_in &&
        reg_addr_in == 7'h40 |=> reg_rdata_out == 32'h0)
        else $error("clock block 0 not fixed");
    a_link_release: assert property (link_en_in &&
        $past(link_en_in) && $past(link_en_in, 2) |->
        pin_oe_out[31:16] == 16'h0000) else $error("link pins driven");
    a_od_low_only: assert property (settled && ctl0_q[CTL_EN] &&
        ctl0_q[CTL_OUT] && ctl0_q[CTL_OD] && pin_oe_out[0] |->
        !pin_out[0]) else $error("open drain drove high");
    a_input_floats: assert property (settled &&
        ctl0_q[CTL_EN] && !ctl0_q[CTL_OUT] |-> !pin_oe_out[0])
        else $error("input pin driven");
    a_count_steps: assert property (reg_rd_in &&
        reg_addr_in == 7'h04 && cnt_rd_q && settled && ctl0_q[CTL_EN] &&
        ctl0_q[10:8] == 3'h0 |=> reg_rdata_out[15:0] ==
        $past(reg_rdata_out[15:0]) + 16'h0001)
        else $error("counter did not step by one");

    // main scenarios reached
    c_event: cover property (event_out[0]);
    c_strobe: cover property (strobe_to_external_out[2]);
    c_link: cover property (link_en_in && pin_oe_out[15:8] != 8'h00);
endmodule // timed_io_checks

bind timed_io_ports timed_io_checks u_checks (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .pin_out(pin_out), .pin_oe_out(pin_oe_out), .link_en_in(link_en_in),
    .strobe_to_external_out(strobe_to_external_out),
    .event_out(event_out)
);
